// File: hdl/sgp_pkg.sv
// package of offsets, field positions, reset values and timing for the global policy control bank
package sgp_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL_A    = 8'h03;
	localparam logic [7:0] ADDR_CTRL_B    = 8'h04;
	localparam logic [7:0] ADDR_AGE_STAT  = 8'h08;
	// control a field positions
	localparam int BIT_AGE_EN      = 2;
	localparam int BIT_FAST_AGE    = 1;
	localparam int BIT_AGGR_BACKOFF = 0;
	// control b field positions
	localparam int BIT_VLAN_DISCARD = 7;
	localparam int BIT_MCAST_STORM_DIS = 6;
	localparam int BIT_BP_MODE     = 5;
	localparam int BIT_FAIR_MODE   = 4;
	localparam int BIT_NO_COLL_DROP = 3;
	// reset values (strap bits replaced at reset release)
	localparam logic [7:0] RESET_CTRL_A = 8'h04;
	localparam logic [7:0] RESET_CTRL_B = 8'hf0;
	localparam logic [7:0] WMASK_CTRL_A = 8'h07;
	localparam logic [7:0] WMASK_CTRL_B = 8'hf8;
	// excessive collision threshold
	localparam logic [4:0] COLL_LIMIT = 5'h10;
	// broadcast address and multicast bit index
	localparam logic [47:0] BCAST_DA  = 48'hffffffffffff;
	localparam int          MCAST_BIT = 40;
	// aging periods
	localparam longint CLK_HZ        = 125000000;
	localparam longint FAST_AGE_US   = 800;
	localparam longint NORM_AGE_S    = 300;
	localparam longint FAST_AGE_CYC  = FAST_AGE_US * CLK_HZ / 1000000;
	localparam longint NORM_AGE_CYC  = NORM_AGE_S * CLK_HZ;
endpackage

// File: hdl/sgp_policy_regs.sv
// global policy control register bank with aging timer and policy decode
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
// Function
// RULE_01: aging enable bit gates address aging ticks
// RULE_02: aging bit reset follows aging strap
// RULE_03: fast-age bit selects 800 us period
// RULE_04: aggressive back-off for half-duplex ports
// RULE_05: back-off bit reset follows its strap
// RULE_06: discard bit set blocks all VLAN crossing
// RULE_07: cleared lets only known unicast cross
// RULE_08: storm disable set regulates broadcast only
// RULE_09: cleared also regulates DA bit 40 frames
// RULE_10: back-pressure mode carrier-sense or collision
// RULE_11: fair mode drops non-flow-control port packets
// RULE_12: unfair mode flow-controls the flow-control port
// RULE_13: keep retrying or drop after 16 collisions
// RULE_14: collision bit reset follows its strap
// RULE_15: after fast cycle return to 300 s
// RULE_16: straps captured once at reset release
module sgp_policy_regs
	import sgp_pkg::*;
#(
	parameter longint FAST_CYCLES = FAST_AGE_CYC,
	parameter longint NORM_CYCLES = NORM_AGE_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        clkEn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// strap pins
	input  wire logic        aging_strap_pin,
	input  wire logic        backoff_strap_pin,
	input  wire logic        collision_drop_strap_pin,
	// frame classification from the datapath
	input  wire logic [47:0] frameDa,
	input  wire logic        frameKnownUnicast,
	input  wire logic        frameSameVlan,
	input  wire logic [4:0]  collisionCount,
	input  wire logic        srcFlowCtrl,
	input  wire logic        sharedDestConflict,
	// policy outputs
	output logic             ageTick,
	output logic             agingActive,
	output logic             aggressiveBackoff,
	output logic             crossAllowed,
	output logic             stormRegulate,
	output logic             carrierSenseBp,
	output logic             dropNonFcPort,
	output logic             throttleFcPort,
	output logic             collisionDrop
);

	typedef enum logic [1:0] {SGP_STRAP_WAIT, SGP_STRAP_FILL, SGP_STRAP_TAKE, SGP_RUN} sgp_boot_e;

	logic [7:0]  ctrlA;
	logic [7:0]  ctrlB;
	logic [7:0]  next_ctrlA;
	logic [7:0]  next_ctrlB;
	sgp_boot_e   bootState;
	sgp_boot_e   next_bootState;
	logic [2:0]  strapA;
	logic [2:0]  strapB;
	logic [2:0]  strapC;
	logic [2:0]  next_strapA;
	logic [2:0]  next_strapB;
	logic [2:0]  next_strapC;
	logic [35:0] ageCount;
	logic [35:0] next_ageCount;
	logic        fastRun;
	logic        next_fastRun;
	logic        ageTickQ;
	logic        next_ageTickQ;
	logic        pready_n;
	logic [31:0] prdata_n;
	logic        pslverr_n;
	logic [6:0]  polQ;
	logic [6:0]  next_polQ;
	logic [35:0] agePeriod;
	logic        regHit;

	// strap synchroniser next values, three stages
	always_comb begin
		next_strapA = {collision_drop_strap_pin, backoff_strap_pin, aging_strap_pin};
		next_strapB = strapA;
		next_strapC = strapB;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			strapA <= 3'h0;
			strapB <= 3'h0;
			strapC <= 3'h0;
		end else if (clkEn) begin
			strapA <= next_strapA;
			strapB <= next_strapB;
			strapC <= next_strapC;
		end
	end

	// boot sequence: let the sync stages fill before comparing, take the straps once, then run
	always_comb begin
		next_bootState = bootState;
		unique case (bootState)
			SGP_STRAP_WAIT: next_bootState = SGP_STRAP_FILL;
			SGP_STRAP_FILL: next_bootState = SGP_STRAP_TAKE;
			SGP_STRAP_TAKE: if (strapB == strapC) next_bootState = SGP_RUN;
			SGP_RUN:        next_bootState = SGP_RUN;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bootState <= SGP_STRAP_WAIT;
		end else if (clkEn) begin
			bootState <= next_bootState;
		end
	end

	assign regHit = (paddr == ADDR_CTRL_A) || (paddr == ADDR_CTRL_B) || (paddr == ADDR_AGE_STAT);

	// register writes and strap capture
	always_comb begin
		next_ctrlA = ctrlA;
		next_ctrlB = ctrlB;
		if (bootState == SGP_STRAP_TAKE && strapB == strapC) begin
			next_ctrlA[BIT_AGE_EN]       = strapC[0]; // [RULE_02] [RULE_16]
			next_ctrlA[BIT_AGGR_BACKOFF] = strapC[1]; // [RULE_05] [RULE_16]
			next_ctrlB[BIT_NO_COLL_DROP] = strapC[2]; // [RULE_14] [RULE_16]
		end else if (psel && penable && pwrite && bootState == SGP_RUN) begin
			if (paddr == ADDR_CTRL_A) begin
				next_ctrlA = pwdata[7:0] & WMASK_CTRL_A;
			end else if (paddr == ADDR_CTRL_B) begin
				next_ctrlB = pwdata[7:0] & WMASK_CTRL_B;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrlA <= RESET_CTRL_A;
			ctrlB <= RESET_CTRL_B;
		end else if (clkEn) begin
			ctrlA <= next_ctrlA;
			ctrlB <= next_ctrlB;
		end
	end

	// apb answer: one access cycle, reads zero-extended, unmapped flagged
	always_comb begin
		pready_n  = psel && !penable;
		pslverr_n = psel && !penable && !regHit;
		prdata_n  = 32'h0;
		if (psel && !penable) begin
			if (paddr == ADDR_CTRL_A) begin
				prdata_n = {24'h0, ctrlA};
			end else if (paddr == ADDR_CTRL_B) begin
				prdata_n = {24'h0, ctrlB};
			end else if (paddr == ADDR_AGE_STAT) begin
				prdata_n = {30'h0, fastRun, agingActive};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (clkEn) begin
			pready  <= pready_n;
			pslverr <= pslverr_n;
			prdata  <= prdata_n;
		end
	end

	// aging timer: fast period while the fast-age bit is set, normal period again from the first tick after it clears
	assign agePeriod = fastRun ? FAST_CYCLES[35:0] : NORM_CYCLES[35:0]; // [RULE_03] [RULE_15]

	always_comb begin
		next_ageCount = ageCount;
		next_fastRun  = fastRun;
		next_ageTickQ = 1'b0;
		if (ctrlA[BIT_FAST_AGE] && !fastRun) begin
			next_fastRun  = 1'b1; // [RULE_03]
			next_ageCount = 36'h0;
		end else if (!ctrlA[BIT_AGE_EN] || bootState != SGP_RUN) begin
			next_ageCount = 36'h0; // [RULE_01]
		end else if (ageCount >= agePeriod - 36'h1) begin
			next_ageCount = 36'h0;
			next_ageTickQ = 1'b1;
			if (fastRun && !ctrlA[BIT_FAST_AGE]) begin
				next_fastRun = 1'b0; // [RULE_15]
			end
		end else begin
			next_ageCount = ageCount + 36'h1;
		end
		if (!ctrlA[BIT_FAST_AGE] && fastRun && !ctrlA[BIT_AGE_EN]) begin
			next_fastRun = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ageCount <= 36'h0;
			fastRun  <= 1'b0;
			ageTickQ <= 1'b0;
		end else if (clkEn) begin
			ageCount <= next_ageCount;
			fastRun  <= next_fastRun;
			ageTickQ <= next_ageTickQ;
		end
	end

	assign ageTick = ageTickQ;

	// policy decode, registered
	always_comb begin
		next_polQ[0] = ctrlA[BIT_AGE_EN] && bootState == SGP_RUN; // [RULE_01]
		next_polQ[1] = ctrlA[BIT_AGGR_BACKOFF]; // [RULE_04]
		// known unicast may cross only when discard is off
		next_polQ[2] = frameSameVlan || (!ctrlB[BIT_VLAN_DISCARD] && frameKnownUnicast); // [RULE_06] [RULE_07]
		// broadcast always, multicast only when protection covers it
		next_polQ[3] = (frameDa == BCAST_DA) ||
			(!ctrlB[BIT_MCAST_STORM_DIS] && frameDa[MCAST_BIT]); // [RULE_08] [RULE_09]
		next_polQ[4] = ctrlB[BIT_BP_MODE]; // [RULE_10]
		next_polQ[5] = ctrlB[BIT_FAIR_MODE] && sharedDestConflict && !srcFlowCtrl; // [RULE_11]
		next_polQ[6] = !ctrlB[BIT_FAIR_MODE] && sharedDestConflict && srcFlowCtrl; // [RULE_12]
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			polQ          <= 7'h0;
			collisionDrop <= 1'b0;
		end else if (clkEn) begin
			polQ          <= next_polQ;
			collisionDrop <= !ctrlB[BIT_NO_COLL_DROP] && (collisionCount >= COLL_LIMIT); // [RULE_13]
		end
	end

	assign agingActive       = polQ[0];
	assign aggressiveBackoff = polQ[1];
	assign crossAllowed      = polQ[2];
	assign stormRegulate     = polQ[3];
	assign carrierSenseBp    = polQ[4];
	assign dropNonFcPort     = polQ[5];
	assign throttleFcPort    = polQ[6];

endmodule

// File: tb/sgp_policy_assertions.sv
// assertion checker for the global policy control bank
`timescale 1ns/1ps
module sgp_policy_assertions
	import sgp_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        clkEn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic [47:0] frameDa,
	input wire logic        frameSameVlan,
	input wire logic        frameKnownUnicast,
	input wire logic [4:0]  collisionCount,
	input wire logic        crossAllowed,
	input wire logic        stormRegulate,
	input wire logic        collisionDrop,
	input wire logic        ageTick
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_rdy; psel && !penable && clkEn |=> pready; endproperty
	property p_pulse; pready && clkEn |=> !pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
	property p_same; clkEn && frameSameVlan |=> crossAllowed; endproperty
	property p_conf; clkEn && !frameSameVlan && !frameKnownUnicast |=> !crossAllowed; endproperty
	property p_bcast; clkEn && frameDa == BCAST_DA |=> stormRegulate; endproperty
	property p_plain; clkEn && !frameDa[MCAST_BIT] |=> !stormRegulate; endproperty
	property p_coll; clkEn && collisionCount < COLL_LIMIT |=> !collisionDrop; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	a_pulse: assert property (p_pulse) else $error("ready too long");
	a_err: assert property (p_err) else $error("error without ready");
	a_upper: assert property (p_upper) else $error("upper read bits set");
	a_same: assert property (p_same) else $error("same vlan blocked");
	a_conf: assert property (p_conf) else $error("crossing leaked");
	a_bcast: assert property (p_bcast) else $error("broadcast unregulated");
	a_plain: assert property (p_plain) else $error("unicast regulated");
	a_coll: assert property (p_coll) else $error("early drop");
	c_xfer: cover property (psel && penable && pready);
	c_err: cover property (pslverr);
	c_tick: cover property (ageTick);
	c_drop: cover property (collisionDrop);
endmodule
bind sgp_policy_regs sgp_policy_assertions chk (.clk_sys, .rstn, .clkEn, .psel, .penable, .pready,
	.pslverr, .prdata, .frameDa, .frameSameVlan, .frameKnownUnicast, .collisionCount, .crossAllowed,
	.stormRegulate, .collisionDrop, .ageTick);

// File: tb/switch_global_policy_controls_tb.sv
// self-checking testbench for the global policy control bank
`timescale 1ns/1ps
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module switch_global_policy_controls_tb;
	import sgp_pkg::*;
	logic clk_sys = 0, rstn = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [7:0] paddr = 0, ra, rb;
	logic [31:0] pwdata = 0, prdata, rd;
	logic aging_strap_pin = 1, backoff_strap_pin = 0, collision_drop_strap_pin = 0;
	logic [47:0] frameDa = 0;
	logic frameKnownUnicast = 0, frameSameVlan = 0, srcFlowCtrl = 0, sharedDestConflict = 0;
	logic [4:0] collisionCount = 0;
	logic ageTick, agingActive, aggressiveBackoff, crossAllowed, stormRegulate;
	logic carrierSenseBp, dropNonFcPort, throttleFcPort, collisionDrop;
	int bad_count = 0, cmp_count = 0, g;
	sgp_policy_regs #(.FAST_CYCLES(20), .NORM_CYCLES(50)) uut (.clk_sys, .rstn, .clkEn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .aging_strap_pin, .backoff_strap_pin,
		.collision_drop_strap_pin, .frameDa, .frameKnownUnicast, .frameSameVlan, .collisionCount,
		.srcFlowCtrl, .sharedDestConflict, .ageTick, .agingActive, .aggressiveBackoff, .crossAllowed,
		.stormRegulate, .carrierSenseBp, .dropNonFcPort, .throttleFcPort, .collisionDrop);
	always #4 clk_sys = ~clk_sys;
	// one apb transfer, held until ready is sampled
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		begin
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk_sys);
			penable <= 1;
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
			end while (pready !== 1 && n < 20);
			if (pready !== 1) bad_count++;
			rd = prdata;
			err = pslverr;
			psel <= 0;
			penable <= 0;
			@(posedge clk_sys);
		end
	endtask
	task rdchk(input logic [7:0] a, input logic [7:0] e);
		begin
			apb(0, a, 0);
			`CHK(rd, {24'h0, e})
			`CHK(err, 1'b0)
		end
	endtask
	// random frame, outputs compared with the model two edges later
	task frame;
		logic [47:0] d;
		logic k, f, c;
		begin
			d = $urandom_range(1) ? BCAST_DA : {16'($urandom), 32'($urandom)};
			k = !d[40] & 1'($urandom);
			f = 1'($urandom);
			c = 1'($urandom);
			frameDa <= d;
			frameKnownUnicast <= k;
			frameSameVlan <= 1'($urandom);
			srcFlowCtrl <= f;
			sharedDestConflict <= c;
			collisionCount <= 5'($urandom_range(20, 12));
			repeat (2) @(posedge clk_sys);
			`CHK(crossAllowed, frameSameVlan | (~rb[7] & k))
			`CHK(stormRegulate, (d == BCAST_DA) | (~rb[6] & d[40]))
			`CHK(carrierSenseBp, rb[5])
			`CHK(dropNonFcPort, rb[4] & c & ~f)
			`CHK(throttleFcPort, ~rb[4] & c & f)
			`CHK(collisionDrop, (collisionCount >= COLL_LIMIT) & ~rb[3])
			`CHK(aggressiveBackoff, ra[0])
		end
	endtask
	// tick to tick distance in cycles
	task gap;
		begin
			g = 0;
			do begin @(posedge clk_sys); g++; end while (ageTick !== 1 && g < 400);
			g = 0;
			do begin @(posedge clk_sys); g++; end while (ageTick !== 1 && g < 400);
		end
	endtask
	task finish_test;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
			else $display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		finish_test;
	end
	initial begin
		void'($urandom(32'h9d8f2176));
		@(posedge clk_sys);
		backoff_strap_pin <= 1'($urandom);
		collision_drop_strap_pin <= 1'($urandom);
		repeat (10) @(posedge clk_sys);
		rstn <= 1;
		repeat (6) @(posedge clk_sys);
		ra = {5'h0, aging_strap_pin, 1'b0, backoff_strap_pin};
		rb = 8'hf0 | {4'h0, collision_drop_strap_pin, 3'h0};
		aging_strap_pin <= 0;
		backoff_strap_pin <= ~backoff_strap_pin;
		rdchk(ADDR_CTRL_A, ra);
		rdchk(ADDR_CTRL_B, rb);
		apb(0, 8'h10, 0);
		`CHK({err, rd}, {1'b1, 32'h0})
		for (int i = 0; i < 10; i++) begin
			ra = 8'h4 | 8'($urandom_range(1));
			rb = 8'($urandom) & WMASK_CTRL_B;
			apb(1, ADDR_CTRL_A, {24'h0, ra});
			apb(1, ADDR_CTRL_B, {24'h0, rb});
			rdchk(ADDR_CTRL_B, rb);
			repeat (12) frame;
		end
		gap;
		`CHK(g >= 49 && g <= 51, 1'b1)
		apb(1, ADDR_CTRL_A, 32'h6);
		repeat (2) gap;
		`CHK(g >= 19 && g <= 21, 1'b1)
		apb(1, ADDR_CTRL_A, 32'h4);
		repeat (2) gap;
		`CHK(g >= 49 && g <= 51, 1'b1)
		apb(1, ADDR_CTRL_A, 32'h0);
		g = 0;
		repeat (150) begin @(posedge clk_sys); g += ageTick; end
		`CHK({g == 0, agingActive}, 2'b10)
		finish_test;
	end
endmodule
